//--- src/trevf_event_flags.sv
// Event flags, interrupt request and chain-pointer status of the ring controller
// Notes on behaviour
// - Any set event bit pulls interrupt_request_n low unless interrupts masked.
// - Reading the event register returns it, then clears all eight bits.
// - Entering isolate from network or diagnostic state also sets bit 0.
// - Unacknowledged data frame (NAK or two silent tries) sets bit 1.
// - Token received by this node sets bit 2.
// - Good frame fully received and stored sets bit 3.
// - Host zeroes status bytes; device writes non-zero status per good frame.
// - At least one data frame transmitted sets bit 4.
// - New successor found (failed pass or scan frame) sets bit 5.
// - Receiver overrun sets bit 6.
// - Transmit underrun: abort, set bit 7, no retry, pass token.
// - Event meanings apply outside diagnostic mode only.
// - Timers count in units of 64 controller clocks.
// - Dead timer bounds gap between valid frames; must exceed ack timer.
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module trevf_event_flags
	import trevf_pkg::*;
(
	input wire logic ref_clk, // 40 MHz controller clock
	input wire logic sys_rst, // async reset, active high
	input wire logic [3:0] reg_addr, // register address
	input wire logic [15:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [15:0] reg_rdata, // read data, cycle after strobe
	input wire logic ev_ack_failure, // pulse: NAK or no reply twice
	input wire logic ev_token_arrived, // pulse: token received
	input wire logic ev_frame_received, // pulse: good frame stored
	input wire logic ev_frames_sent, // pulse: data frame(s) sent
	input wire logic ev_new_successor, // pulse: successor changed
	input wire logic ev_rx_overrun, // pulse: receive data lost
	input wire logic ev_tx_underrun, // pulse: transmit DMA too late
	input wire logic ev_valid_frame, // pulse: valid frame seen on net
	input wire logic rx_ptr_next_held, // rx next-buffer address held
	input wire logic tx_ptr_next_held, // tx next-frame address held
	input wire logic tx_ptr_zero_link, // tx pointer on zero link
	input wire logic mode_isolate_ack, // engine confirms isolate
	output logic send_abort, // pulse: abort the current frame
	output logic pass_token, // pulse: pass token, no retry
	output logic scan_start, // pulse: enter scan mode
	output logic interrupt_request_n // interrupt request, active low
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] flags;
		logic [7:0] ctrl;
		logic [7:0] ack_limit;
		logic [7:0] dead_limit;
		logic [5:0] prescale;
		logic ring_member;
		logic scan;
		logic rx_ptr_valid;
		logic tx_ptr_valid;
		trevf_mode_t mode;
		logic [15:0] rdata;
		logic send_abort;
		logic pass_token;
		logic scan_start;
		logic irq_n;
	} trevf_state_t;

	trevf_state_t s_q, s_d;
	logic tick;
	logic dead_expired;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		return a == r;
	endfunction

	// ------------------------------------------------------------------
	// Dead-network timer
	// ------------------------------------------------------------------
	assign tick = (s_q.prescale == TICK_LAST);

	trevf_timer u_dead (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.restart(ev_valid_frame),
		.run(s_q.mode == MODE_NETWORK && !s_q.ctrl[CTL_TIMER_OFF]),
		.tick(tick),
		.limit(s_q.dead_limit),
		.expired(dead_expired)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		logic [7:0] set_v;
		logic diag;
		set_v = '0;
		diag = (s_q.mode == MODE_DIAG);
		s_d = s_q;
		s_d.send_abort = 1'b0;
		s_d.pass_token = 1'b0;
		s_d.scan_start = 1'b0;
		s_d.rdata = '0;
		s_d.prescale = tick ? 6'h00 : s_q.prescale + 6'h01;

		// Mode tracking; isolate entry is confirmed by the engine
		if (s_q.mode != MODE_ISOLATE && mode_isolate_ack) begin
			s_d.mode = MODE_ISOLATE;
			set_v[EV_DEAD_OR_MODE] = 1'b1;
		end else if (s_q.mode == MODE_ISOLATE && !s_q.ctrl[CTL_ISOLATE]) begin
			s_d.mode = MODE_NETWORK;
		end else if (s_q.mode == MODE_ISOLATE && s_q.ctrl[CTL_DIAG]) begin
			s_d.mode = MODE_DIAG;
		end

		if (dead_expired && s_q.mode == MODE_NETWORK) begin
			set_v[EV_DEAD_OR_MODE] = 1'b1;
			s_d.ring_member = 1'b0;
			if (s_q.ctrl[CTL_INIT_RING]) begin
				s_d.scan = 1'b1;
				s_d.scan_start = 1'b1;
			end
		end
		if (ev_token_arrived) begin
			s_d.ring_member = 1'b1;
			s_d.scan = 1'b0;
		end

		// Engine events only carry these meanings outside diagnostics
		if (!diag) begin
			set_v[EV_ACK_FAILURE] = ev_ack_failure;
			set_v[EV_TOKEN_ARRIVED] = ev_token_arrived;
			set_v[EV_FRAME_RECEIVED] = ev_frame_received;
			set_v[EV_FRAMES_SENT] = ev_frames_sent;
			set_v[EV_NEW_SUCCESSOR] = ev_new_successor;
			set_v[EV_RX_OVERRUN] = ev_rx_overrun;
			set_v[EV_TX_UNDERRUN] = ev_tx_underrun;
			if (ev_tx_underrun) begin
				s_d.send_abort = 1'b1;
				s_d.pass_token = 1'b1;
			end
		end

		// Chain pointer status
		s_d.rx_ptr_valid = rx_ptr_next_held;
		if (tx_ptr_next_held) begin
			s_d.tx_ptr_valid = 1'b1;
		end else if (tx_ptr_zero_link) begin
			s_d.tx_ptr_valid = 1'b0;
		end

		// Register reads
		if (reg_rd) begin
			if (hit(reg_addr, ADDR_EVENT_FLAGS)) begin
				s_d.rdata = {8'h00, s_q.flags};
				s_d.flags = '0;
			end else if (hit(reg_addr, ADDR_CONTROL)) begin
				s_d.rdata = {8'h00, s_q.ctrl};
			end else if (hit(reg_addr, ADDR_STATUS)) begin
				s_d.rdata = {10'h000, s_q.mode, s_q.tx_ptr_valid,
					s_q.rx_ptr_valid, s_q.scan, s_q.ring_member};
			end else if (hit(reg_addr, ADDR_TIMERS)) begin
				s_d.rdata = {s_q.dead_limit, s_q.ack_limit};
			end
		end

		// Register writes
		if (reg_wr) begin
			if (hit(reg_addr, ADDR_CONTROL)) begin
				s_d.ctrl = reg_wdata[7:0];
			end else if (hit(reg_addr, ADDR_TIMERS)) begin
				s_d.ack_limit = reg_wdata[7:0];
				s_d.dead_limit = reg_wdata[15:8]; // host keeps above ack
			end
		end

		// A new event wins over the clear by read
		s_d.flags = s_d.flags | set_v;
		s_d.irq_n = !((|s_d.flags) && !s_d.ctrl[CTL_INT_MASK]);
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.ctrl <= CTL_RESET;
			s_q.ack_limit <= TIMER_RESET;
			s_q.dead_limit <= TIMER_RESET;
			s_q.mode <= MODE_ISOLATE;
			s_q.irq_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata = s_q.rdata;
	assign send_abort = s_q.send_abort;
	assign pass_token = s_q.pass_token;
	assign scan_start = s_q.scan_start;
	assign interrupt_request_n = s_q.irq_n;

endmodule // trevf_event_flags
`default_nettype wire

//--- src/trevf_pkg.sv
// Package: register map, field positions and timing constants of the event-flag block
package trevf_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [3:0] ADDR_EVENT_FLAGS = 4'h0; // read clears
	localparam logic [3:0] ADDR_CONTROL = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_TIMERS = 4'h3; // [7:0] ack, [15:8] dead

	// ------------------------------------------------------------------
	// Event flag positions
	// ------------------------------------------------------------------
	localparam int EV_DEAD_OR_MODE = 0;
	localparam int EV_ACK_FAILURE = 1;
	localparam int EV_TOKEN_ARRIVED = 2;
	localparam int EV_FRAME_RECEIVED = 3;
	localparam int EV_FRAMES_SENT = 4;
	localparam int EV_NEW_SUCCESSOR = 5;
	localparam int EV_RX_OVERRUN = 6;
	localparam int EV_TX_UNDERRUN = 7;

	// ------------------------------------------------------------------
	// Control bit positions
	// ------------------------------------------------------------------
	localparam int CTL_ISOLATE = 0;
	localparam int CTL_INT_MASK = 1;
	localparam int CTL_TIMER_OFF = 2;
	localparam int CTL_INIT_RING = 3;
	localparam int CTL_DIAG = 4;
	localparam logic [7:0] CTL_RESET = 8'h01; // isolated after reset

	// ------------------------------------------------------------------
	// Status bit positions
	// ------------------------------------------------------------------
	localparam int ST_RING_MEMBER = 0;
	localparam int ST_SCAN = 1;
	localparam int ST_RX_PTR_VALID = 2;
	localparam int ST_TX_PTR_VALID = 3;
	localparam int ST_MODE_LO = 4; // two-bit mode code

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int TICK_CLOCKS = 64; // timer base in controller clocks
	localparam logic [5:0] TICK_LAST = 6'(TICK_CLOCKS - 1);
	localparam logic [7:0] TIMER_RESET = 8'hff;

	typedef enum logic [1:0] {
		MODE_ISOLATE = 2'b00,
		MODE_NETWORK = 2'b01,
		MODE_DIAG = 2'b11
	} trevf_mode_t;

endpackage : trevf_pkg

//--- src/trevf_timer.sv
// Tick-based down counter used for the dead-network timeout
`timescale 1ns/1ps
`default_nettype none
module trevf_timer
	import trevf_pkg::*;
(
	input wire logic ref_clk, // controller clock
	input wire logic sys_rst, // async reset, active high
	input wire logic restart, // reload the count
	input wire logic run, // count while high
	input wire logic tick, // one pulse per time unit
	input wire logic [7:0] limit, // timeout in time units
	output logic expired // one-cycle pulse
);

	typedef struct packed {
		logic [7:0] cnt;
		logic armed;
		logic expired;
	} trevf_timer_state_t;

	trevf_timer_state_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.expired = 1'b0;
		// First running cycle loads the limit, later cycles count ticks
		if (restart || !run || !s_q.armed) begin
			s_d.cnt = limit;
			s_d.armed = run;
		end else if (tick) begin
			if (s_q.cnt <= 8'h01) begin
				s_d.expired = 1'b1;
				s_d.cnt = limit; // Periodic: fires again if net stays quiet
			end else begin
				s_d.cnt = s_q.cnt - 8'h01;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign expired = s_q.expired;

endmodule // trevf_timer
`default_nettype wire

//--- verification/token_ring_event_flags_bench.sv
// Bench: scenario tasks for the ring event-flag block
`timescale 1ns/1ps
`default_nettype none
module token_ring_event_flags_bench
	import trevf_pkg::*;
;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] req = 8'h00;
	logic rx_held = 1'b0;
	logic tx_held = 1'b0;
	logic tx_zero = 1'b0;
	logic valid_frame = 1'b0;
	logic [15:0] reg_rdata;
	logic [15:0] d;
	logic [7:0] ev;
	logic send_abort, pass_token, scan_start, interrupt_request_n;
	int error_cnt = 0;
	int checks = 0;
	int scans = 0;
	trevf_engine_model eng_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.req(req), .ev(ev));
	trevf_event_flags dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_ack_failure(ev[1]),
		.ev_token_arrived(ev[2]), .ev_frame_received(ev[3]),
		.ev_frames_sent(ev[4]), .ev_new_successor(ev[5]),
		.ev_rx_overrun(ev[6]), .ev_tx_underrun(ev[7]),
		.ev_valid_frame(valid_frame), .rx_ptr_next_held(rx_held),
		.tx_ptr_next_held(tx_held), .tx_ptr_zero_link(tx_zero),
		.mode_isolate_ack(ev[0]), .send_abort(send_abort),
		.pass_token(pass_token), .scan_start(scan_start),
		.interrupt_request_n(interrupt_request_n));
	always #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (scan_start === 1'b1) scans++;
	task automatic chk(input string nm, input logic [15:0] got, exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	// Two edges: model registers the request, then the block takes it
	task automatic fire(input logic [7:0] v);
		@(posedge ref_clk);
		req <= v;
		@(posedge ref_clk);
		req <= 8'h00;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic t_reset();
		rd(ADDR_CONTROL, d);
		chk("control", d, 16'h0001);
		rd(ADDR_EVENT_FLAGS, d);
		chk("flags", d, 16'h0000);
		rd(ADDR_TIMERS, d);
		chk("timers", d, 16'hffff);
		rd(4'h9, d);
		chk("unmapped", d, 16'h0000);
		chk("irq_n", 16'(interrupt_request_n), 16'h0001);
		$display("reset test done");
	endtask
	task automatic t_events();
		for (int i = 1; i < 8; i++) begin
			fire(8'(1 << i));
			chk("irq_n", 16'(interrupt_request_n), 16'h0000);
			chk("abort", {14'h0, send_abort, pass_token},
				(i == 7) ? 16'h0003 : 16'h0000);
			rd(ADDR_EVENT_FLAGS, d);
			chk("flags", d, 16'(1 << i));
			chk("irq_n", 16'(interrupt_request_n), 16'h0001);
		end
		$display("event test done");
	endtask
	task automatic t_mask();
		wr(ADDR_CONTROL, 16'h0003);
		fire(8'h04);
		chk("masked irq_n", 16'(interrupt_request_n), 16'h0001);
		wr(ADDR_CONTROL, 16'h0001);
		@(posedge ref_clk);
		#1;
		chk("unmasked irq_n", 16'(interrupt_request_n), 16'h0000);
		@(posedge ref_clk);
		req <= 8'h02;
		@(posedge ref_clk);
		req <= 8'h00;
		reg_addr <= ADDR_EVENT_FLAGS;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		chk("flags", d, 16'h0004);
		rd(ADDR_EVENT_FLAGS, d);
		chk("same cycle event", d, 16'h0002);
		// Read in the cycle right after the events are taken
		@(posedge ref_clk);
		req <= 8'h84;
		@(posedge ref_clk);
		req <= 8'h00;
		@(posedge ref_clk);
		reg_addr <= ADDR_EVENT_FLAGS;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		chk("next cycle read", d, 16'h0084);
		chk("irq_n after read", 16'(interrupt_request_n), 16'h0001);
		$display("mask test done");
	endtask
	task automatic t_diag();
		wr(ADDR_CONTROL, 16'h0011);
		repeat (3) @(posedge ref_clk);
		fire(8'h84);
		rd(ADDR_EVENT_FLAGS, d);
		chk("diag flags", d, 16'h0000);
		wr(ADDR_CONTROL, 16'h0001);
		fire(8'h01);
		rd(ADDR_EVENT_FLAGS, d);
		chk("isolate flag", d, 16'h0001);
		tx_held <= 1'b1;
		rx_held <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rd(ADDR_STATUS, d);
		chk("ptr valid", 16'(d[3:2]), 16'h0003);
		tx_held <= 1'b0;
		tx_zero <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rd(ADDR_STATUS, d);
		chk("tx ptr clear", 16'(d[ST_TX_PTR_VALID]), 16'h0000);
		$display("diag test done");
	endtask
	task automatic t_dead();
		int n = 0;
		wr(ADDR_TIMERS, 16'h0201);
		rd(ADDR_TIMERS, d);
		chk("timers", d, 16'h0201);
		wr(ADDR_CONTROL, 16'h0008);
		// Frames every 32 clocks keep a two-unit dead timer from running out
		repeat (10) begin
			@(posedge ref_clk);
			valid_frame <= 1'b1;
			@(posedge ref_clk);
			valid_frame <= 1'b0;
			repeat (30) @(posedge ref_clk);
		end
		rd(ADDR_EVENT_FLAGS, d);
		chk("busy net flags", d, 16'h0000);
		rd(ADDR_STATUS, d);
		chk("network mode", 16'(d[ST_MODE_LO +: 2]), 16'h0001);
		// Two units of 64 clocks after the last frame, 34 of them gone
		while (interrupt_request_n !== 1'b0 && n < 400) begin
			@(posedge ref_clk);
			#1 n++;
		end
		chk("dead delay", 16'(n >= 30 && n <= 100), 16'h0001);
		rd(ADDR_EVENT_FLAGS, d);
		chk("dead flag", d, 16'h0001);
		rd(ADDR_STATUS, d);
		chk("ring member", 16'(d[ST_RING_MEMBER]), 16'h0000);
		chk("scan bit", 16'(d[ST_SCAN]), 16'h0001);
		chk("scan", 16'(scans > 0), 16'h0001);
		wr(ADDR_CONTROL, 16'h0005);
		rd(ADDR_EVENT_FLAGS, d);
		fire(8'h01);
		rd(ADDR_EVENT_FLAGS, d);
		chk("mode flag", d, 16'h0001);
		rd(ADDR_STATUS, d);
		chk("isolate mode", 16'(d[ST_MODE_LO +: 2]), 16'h0000);
		rd(ADDR_CONTROL, d);
		chk("isolate bit", 16'(d[CTL_ISOLATE]), 16'h0001);
		$display("dead timer test done");
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Whole run is under a thousand clocks; this span of 20000 clocks is far beyond it
	initial begin
		#(25 * 20000);
		error_cnt++;
		tally_and_finish();
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_reset();
		t_events();
		t_mask();
		t_diag();
		t_dead();
		tally_and_finish();
	end
endmodule // token_ring_event_flags_bench
`default_nettype wire

//--- verification/trevf_assertions.sv
// Checker: port-level properties of the event-flag block
`timescale 1ns/1ps
`default_nettype none
module trevf_checker
	import trevf_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire logic sys_rst, // reset
	input wire logic [3:0] reg_addr, // address
	input wire logic [15:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [15:0] reg_rdata, // read data
	input wire logic ev_token_arrived, // token event
	input wire logic ev_tx_underrun, // underrun event
	input wire logic mode_isolate_ack, // isolate confirm
	input wire logic send_abort, // abort pulse
	input wire logic pass_token, // token pass pulse
	input wire logic interrupt_request_n // irq, active low
);
	logic [7:0] ctl_q;
	logic dg_q;
	logic nd;
	logic ok;
	logic rd0;
	logic cw;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	assign cw = reg_wr && reg_addr == ADDR_CONTROL;
	assign rd0 = reg_rd && reg_addr == ADDR_EVENT_FLAGS;
	assign nd = !dg_q;
	assign ok = nd && !ctl_q[CTL_INT_MASK];
	// Diag is left only once the engine confirms isolate with diag off
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctl_q <= CTL_RESET;
			dg_q <= 1'b0;
		end else begin
			if (cw) ctl_q <= reg_wdata[7:0];
			if (cw && reg_wdata[CTL_DIAG]) dg_q <= 1'b1;
			else if (mode_isolate_ack && !ctl_q[CTL_DIAG]) dg_q <= 1'b0;
		end
	end
	a_token_irq: assert property (ev_token_arrived && ok && !cw |=>
		!interrupt_request_n) else $error("token left irq high");
	a_mask_irq: assert property (ctl_q[CTL_INT_MASK] && !cw |=>
		interrupt_request_n) else $error("masked irq went low");
	a_rdata_idle: assert property (!reg_rd |=>
		reg_rdata == 16'h0000) else $error("read data not zero");
	a_flags_upper: assert property (rd0 |=>
		reg_rdata[15:8] == 8'h00) else $error("flag upper bits set");
	a_token_seen: assert property (ev_token_arrived && nd ##1 rd0 |=>
		reg_rdata[EV_TOKEN_ARRIVED]) else $error("token flag lost");
	a_under_flag: assert property (ev_tx_underrun && nd ##1 rd0 |=>
		reg_rdata[EV_TX_UNDERRUN]) else $error("underrun flag lost");
	a_under_abort: assert property (ev_tx_underrun && nd |=>
		send_abort && pass_token) else $error("no abort on underrun");
	a_abort_cause: assert property (send_abort |->
		$past(ev_tx_underrun)) else $error("abort without underrun");
	cover property (rd0 && !interrupt_request_n);
	cover property (ev_tx_underrun && nd);
	cover property (ev_token_arrived && ctl_q[CTL_INT_MASK]);
endmodule // trevf_checker
bind trevf_event_flags trevf_checker chk_u (.ref_clk(ref_clk),
	.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.ev_token_arrived(ev_token_arrived), .ev_tx_underrun(ev_tx_underrun),
	.mode_isolate_ack(mode_isolate_ack), .send_abort(send_abort),
	.pass_token(pass_token), .interrupt_request_n(interrupt_request_n));
`default_nettype wire

//--- verification/trevf_engine_model.sv
// Engine model: turns bench requests into one-cycle event pulses
`timescale 1ns/1ps
`default_nettype none
module trevf_engine_model (
	input wire logic ref_clk, // controller clock
	input wire logic sys_rst, // async reset
	input wire logic [7:0] req, // bit 0 isolate ack, 1..7 event bits
	output logic [7:0] ev // registered one-cycle pulses
);
	// Launched from the clock like the real engine, never combinational
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ev <= 8'h00;
		end else begin
			ev <= req;
		end
	end
endmodule // trevf_engine_model
`default_nettype wire
